// File: logic/seh_consts.svh
// named offsets, field positions, reset values and timing figures of the eeprom host interface
`ifndef SEH_CONSTS_SVH
`define SEH_CONSTS_SVH
// register indices; byte address is four times the index
`define SEH_IDX_MODE 8'hf1
`define SEH_IDX_PTR 8'hf2
`define SEH_IDX_WDATA 8'hf3
`define SEH_IDX_WSTATE 8'hf4
`define SEH_IDX_RDATA 8'hf5
`define SEH_IDX_RSTATE 8'hf6
`define SEH_IDX_PINCTL 8'hf7
// field positions
`define SEH_LOCK_W 4
`define SEH_MODE_SIZE_BIT 4
`define SEH_WST_DIR_BIT 7
`define SEH_PIN_IN 0
`define SEH_PIN_OUT 1
`define SEH_PIN_CLK 2
`define SEH_PIN_SEL 3
`define SEH_PINCTL_CFG_BIT 0
// write status encodings
`define SEH_WST_READY 2'b11
`define SEH_WST_LOW_HELD 2'b10
`define SEH_WST_BUSY 2'b00
// serial opcodes and frame lengths
`define SEH_OP_READ 2'b10
`define SEH_OP_WRITE 2'b01
`define SEH_OP_EWEN 2'b00
`define SEH_EWEN_ADDR_BIG 8'hc0
`define SEH_EWEN_ADDR_SMALL 8'h30
`define SEH_FRAME_BIG 5'd27
`define SEH_FRAME_SMALL 5'd25
`define SEH_FRAME_EWEN_BIG 5'd11
`define SEH_FRAME_EWEN_SMALL 5'd9
// timing
`define SEH_CLK_PERIOD_NS 25
`define SEH_SK_HALF_NS 500
`define SEH_CS_LOW_NS 250
// bus answers and reset values
`define SEH_RESP_OKAY 2'b00
`define SEH_RESP_SLVERR 2'b10
`define SEH_RST_BYTE 8'h00
`define SEH_RST_WORD 16'h0000
`endif

// File: logic/seh_pkg.sv
// types shared by the eeprom host interface
package seh_pkg;
   typedef enum {SEH_IDLE, SEH_SHIFT, SEH_GAP, SEH_POLL} seh_phase_e;
   typedef enum {SEH_CMD_EWEN, SEH_CMD_WRITE, SEH_CMD_READ, SEH_CMD_POLL} seh_cmd_e;
   typedef logic [1:0] seh_resp_t;
   typedef logic [31:0] seh_data_t;
endpackage

// File: logic/seh_eeprom_if.sv
// serial eeprom host interface: axi4-lite registers and four-wire serial engine
`timescale 1ns/1ps
`default_nettype none
`include "seh_consts.svh"
module seh_eeprom_if #(
   parameter int ADDR_W = 12,
   parameter int SK_HALF_NS = `SEH_SK_HALF_NS,
   parameter int CS_LOW_NS = `SEH_CS_LOW_NS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire seh_pkg::seh_data_t S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output seh_pkg::seh_resp_t S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output seh_pkg::seh_data_t S_AXI_RDATA,
   output seh_pkg::seh_resp_t S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // serial eeprom pins
   input wire logic EEPROM_SERIAL_IN_PIN,
   output logic EEPROM_SERIAL_OUT_PIN,
   output logic EEPROM_SERIAL_CLOCK_PIN,
   output logic EEPROM_SELECT_PIN
);
   import seh_pkg::*;

   localparam int SK_CYC = (SK_HALF_NS + `SEH_CLK_PERIOD_NS - 1) / `SEH_CLK_PERIOD_NS;
   localparam int GAP_CYC = (CS_LOW_NS + `SEH_CLK_PERIOD_NS - 1) / `SEH_CLK_PERIOD_NS;
   localparam logic [7:0] SK_RELOAD = 8'(SK_CYC - 1);
   localparam logic [7:0] GAP_RELOAD = 8'(GAP_CYC - 1);

   // refuse settings the address decode or the counters cannot serve
   generate
      if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr
         $error("ADDR_W must lie between 11 and 32");
      end
      if (SK_CYC < 1 || SK_CYC > 256 || GAP_CYC < 1 || GAP_CYC > 256) begin : g_bad_time
         $error("serial timing does not fit the 8-bit counter");
      end
   endgenerate

   // register hit on a word-aligned index
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction

   // word address inside a locked 32-byte block of the first 128 bytes
   function automatic logic is_locked(input logic [7:0] addr, input logic [3:0] lock);
      is_locked = (addr[7:6] == 2'b00) && lock[addr[5:4]];
   endfunction

   // left-aligned serial frame: start bit, opcode, address, data
   function automatic logic [26:0] frame(input logic [1:0] op, input logic [7:0] addr,
                                         input logic [15:0] data, input logic big);
      if (big) begin
         frame = {1'b1, op, addr, data};
      end else begin
         frame = {1'b1, op, addr[5:0], data, 2'b00};
      end
   endfunction

   // host-visible state
   logic [3:0] lock;
   logic size_big;
   logic cfg_mode;
   logic [3:0] pin_inv;
   logic [7:0] ptr;
   logic wdir;
   logic [1:0] wstate;
   logic [7:0] wlo;
   logic [15:0] wword;
   logic [7:0] wr_addr;
   logic wr_req;
   logic rd_req;
   logic rd_valid;
   logic rd_hi;
   logic [15:0] rd_data;
   // bus state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane;
   // serial engine state
   seh_phase_e phase;
   seh_cmd_e cmd;
   logic [7:0] cnt;
   logic sk_high;
   logic [4:0] nbits;
   logic [26:0] tx;
   logic [15:0] rx;
   logic cs;
   logic eng_wr_done;
   logic eng_rd_done;
   logic [15:0] eng_word;
   logic din_s1;
   logic din_s2;
   logic din;

   // request decode
   logic wr_do;
   logic rd_do;
   logic wr_en;
   logic start_wr;
   logic start_rd;
   logic host_ptr_wr;
   logic byte_pair_wr;
   logic byte_pair_rd;
   logic [1:0] ptr_inc;
   logic [7:0] rd_value;
   logic rd_mapped;
   logic wr_mapped;

   assign wr_do = aw_held && w_held && !S_AXI_BVALID;
   assign rd_do = S_AXI_ARVALID && S_AXI_ARREADY;
   assign wr_en = wr_do && w_lane && cfg_mode;
   assign host_ptr_wr = wr_en && reg_hit(aw_addr, `SEH_IDX_PTR);
   assign byte_pair_wr = wr_en && reg_hit(aw_addr, `SEH_IDX_WDATA)
                         && (wstate == `SEH_WST_LOW_HELD);
   assign byte_pair_rd = rd_do && cfg_mode && reg_hit(S_AXI_ARADDR, `SEH_IDX_RDATA)
                         && rd_valid && rd_hi;
   assign ptr_inc = {1'b0, byte_pair_wr} + {1'b0, byte_pair_rd};
   assign start_wr = (phase == SEH_IDLE) && wr_req;
   assign start_rd = (phase == SEH_IDLE) && !wr_req && rd_req;
   assign din = din_s2 ^ pin_inv[`SEH_PIN_IN];

   // read value and map check
   always_comb begin
      rd_value = `SEH_RST_BYTE;
      rd_mapped = 1'b1;
      if (reg_hit(S_AXI_ARADDR, `SEH_IDX_PINCTL)) begin
         rd_value = {3'b000, pin_inv, cfg_mode};
      end else if (!cfg_mode) begin
         rd_value = `SEH_RST_BYTE;
         rd_mapped = reg_hit(S_AXI_ARADDR, `SEH_IDX_MODE) || reg_hit(S_AXI_ARADDR, `SEH_IDX_PTR)
                     || reg_hit(S_AXI_ARADDR, `SEH_IDX_WDATA)
                     || reg_hit(S_AXI_ARADDR, `SEH_IDX_WSTATE)
                     || reg_hit(S_AXI_ARADDR, `SEH_IDX_RDATA)
                     || reg_hit(S_AXI_ARADDR, `SEH_IDX_RSTATE);
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_MODE)) begin
         rd_value = {3'b000, size_big, lock};
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_PTR)) begin
         rd_value = ptr;
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_WDATA)) begin
         rd_value = `SEH_RST_BYTE;
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_WSTATE)) begin
         rd_value = {wdir, 5'b00000, wstate};
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_RDATA)) begin
         rd_value = rd_hi ? rd_data[15:8] : rd_data[7:0];
      end else if (reg_hit(S_AXI_ARADDR, `SEH_IDX_RSTATE)) begin
         rd_value = {7'b0000000, rd_valid};
      end else begin
         rd_mapped = 1'b0;
      end
   end

   // write map check
   assign wr_mapped = reg_hit(aw_addr, `SEH_IDX_MODE) || reg_hit(aw_addr, `SEH_IDX_PTR)
                      || reg_hit(aw_addr, `SEH_IDX_WDATA) || reg_hit(aw_addr, `SEH_IDX_WSTATE)
                      || reg_hit(aw_addr, `SEH_IDX_RDATA) || reg_hit(aw_addr, `SEH_IDX_RSTATE)
                      || reg_hit(aw_addr, `SEH_IDX_PINCTL);

   // axi write channels: address and data taken in either order, then one response
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SEH_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_byte <= `SEH_RST_BYTE;
         w_lane <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_byte <= S_AXI_WDATA[7:0];
            w_lane <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_do) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_mapped ? `SEH_RESP_OKAY : `SEH_RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // axi read channel: answer one cycle after the address is taken
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= `SEH_RESP_OKAY;
      end else begin
         if (rd_do) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h000000, rd_value};
            S_AXI_RRESP <= rd_mapped ? `SEH_RESP_OKAY : `SEH_RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // mode, lock and pin control
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         lock <= '0;
         size_big <= 1'b0;
         cfg_mode <= 1'b0;
         pin_inv <= '0;
      end else begin
         if (wr_en && reg_hit(aw_addr, `SEH_IDX_MODE)) begin
            lock <= lock | w_byte[`SEH_LOCK_W-1:0];
            size_big <= w_byte[`SEH_MODE_SIZE_BIT];
         end
         if (wr_do && w_lane && reg_hit(aw_addr, `SEH_IDX_PINCTL)) begin
            cfg_mode <= w_byte[`SEH_PINCTL_CFG_BIT];
            pin_inv <= w_byte[`SEH_PIN_SEL+1:`SEH_PIN_IN+1];
         end
      end
   end

   // pointer: host write wins over increments
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ptr <= `SEH_RST_BYTE;
      end else if (host_ptr_wr) begin
         ptr <= w_byte;
      end else begin
         ptr <= ptr + {6'b000000, ptr_inc};
      end
   end

   // write path: direction, byte pairing and write status
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wdir <= 1'b0;
         wstate <= `SEH_WST_READY;
         wlo <= `SEH_RST_BYTE;
         wword <= `SEH_RST_WORD;
         wr_addr <= `SEH_RST_BYTE;
         wr_req <= 1'b0;
      end else begin
         if (wr_en && reg_hit(aw_addr, `SEH_IDX_WSTATE)) begin
            wdir <= w_byte[`SEH_WST_DIR_BIT];
         end
         if (start_wr) begin
            wr_req <= 1'b0;
         end
         if (eng_wr_done) begin
            wstate <= `SEH_WST_READY;
         end else if (wr_en && reg_hit(aw_addr, `SEH_IDX_WDATA)) begin
            if (wstate == `SEH_WST_READY) begin
               wlo <= w_byte;
               wstate <= `SEH_WST_LOW_HELD;
            end else if (wstate == `SEH_WST_LOW_HELD) begin
               wword <= {w_byte, wlo};
               wr_addr <= ptr;
               wstate <= `SEH_WST_BUSY;
               wr_req <= 1'b1;
            end
         end
      end
   end

   // read path: prefetch request, valid flag and byte select
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rd_req <= 1'b0;
         rd_valid <= 1'b0;
         rd_hi <= 1'b0;
         rd_data <= `SEH_RST_WORD;
      end else begin
         // any pointer update, host write or auto-increment, restarts the prefetch in read mode
         if (host_ptr_wr || byte_pair_rd || byte_pair_wr) begin
            rd_req <= !wdir;
            rd_valid <= 1'b0;
            rd_hi <= 1'b0;
         end else begin
            if (start_rd) begin
               rd_req <= 1'b0;
            end
            if (eng_rd_done) begin
               rd_data <= eng_word;
               rd_valid <= !rd_req;
               rd_hi <= 1'b0;
            end else if (rd_do && cfg_mode && rd_valid
                         && reg_hit(S_AXI_ARADDR, `SEH_IDX_RDATA)) begin
               rd_hi <= 1'b1;
            end
         end
      end
   end

   // serial engine: frames on a divided clock, completion poll on the data line
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         phase <= SEH_IDLE;
         cmd <= SEH_CMD_READ;
         cnt <= '0;
         sk_high <= 1'b0;
         nbits <= '0;
         tx <= '0;
         rx <= `SEH_RST_WORD;
         cs <= 1'b0;
         eng_wr_done <= 1'b0;
         eng_rd_done <= 1'b0;
         eng_word <= `SEH_RST_WORD;
      end else begin
         eng_wr_done <= 1'b0;
         eng_rd_done <= 1'b0;
         unique case (phase)
            SEH_IDLE: begin
               if (start_wr) begin
                  if (is_locked(wr_addr, lock)) begin
                     eng_wr_done <= 1'b1;
                  end else begin
                     cmd <= SEH_CMD_EWEN;
                     tx <= frame(`SEH_OP_EWEN, size_big ? `SEH_EWEN_ADDR_BIG
                                 : `SEH_EWEN_ADDR_SMALL, `SEH_RST_WORD, size_big);
                     nbits <= size_big ? `SEH_FRAME_EWEN_BIG : `SEH_FRAME_EWEN_SMALL;
                     cs <= 1'b1;
                     cnt <= SK_RELOAD;
                     phase <= SEH_SHIFT;
                  end
               end else if (start_rd) begin
                  if (is_locked(ptr, lock)) begin
                     eng_word <= `SEH_RST_WORD;
                     eng_rd_done <= 1'b1;
                  end else begin
                     cmd <= SEH_CMD_READ;
                     tx <= frame(`SEH_OP_READ, ptr, `SEH_RST_WORD, size_big);
                     nbits <= size_big ? `SEH_FRAME_BIG : `SEH_FRAME_SMALL;
                     cs <= 1'b1;
                     cnt <= SK_RELOAD;
                     phase <= SEH_SHIFT;
                  end
               end
            end
            SEH_SHIFT: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else if (!sk_high) begin
                  sk_high <= 1'b1;
                  cnt <= SK_RELOAD;
               end else begin
                  sk_high <= 1'b0;
                  rx <= {rx[14:0], din};
                  tx <= {tx[25:0], 1'b0};
                  nbits <= nbits - 5'd1;
                  if (nbits == 5'd1) begin
                     cs <= 1'b0;
                     cnt <= GAP_RELOAD;
                     phase <= SEH_GAP;
                  end else begin
                     cnt <= SK_RELOAD;
                  end
               end
            end
            SEH_GAP: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else begin
                  unique case (cmd)
                     SEH_CMD_EWEN: begin
                        cmd <= SEH_CMD_WRITE;
                        tx <= frame(`SEH_OP_WRITE, wr_addr, wword, size_big);
                        nbits <= size_big ? `SEH_FRAME_BIG : `SEH_FRAME_SMALL;
                        cs <= 1'b1;
                        cnt <= SK_RELOAD;
                        phase <= SEH_SHIFT;
                     end
                     SEH_CMD_WRITE: begin
                        cs <= 1'b1;
                        cnt <= SK_RELOAD;
                        phase <= SEH_POLL;
                     end
                     SEH_CMD_READ: begin
                        eng_word <= rx;
                        eng_rd_done <= 1'b1;
                        phase <= SEH_IDLE;
                     end
                     SEH_CMD_POLL: begin
                        eng_wr_done <= 1'b1;
                        phase <= SEH_IDLE;
                     end
                  endcase
               end
            end
            SEH_POLL: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else if (din) begin
                  cs <= 1'b0;
                  cmd <= SEH_CMD_POLL;
                  cnt <= GAP_RELOAD;
                  phase <= SEH_GAP;
               end
            end
         endcase
      end
   end

   // pin stage: polarity applied, outputs straight from flip-flops
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         EEPROM_SERIAL_OUT_PIN <= 1'b0;
         EEPROM_SERIAL_CLOCK_PIN <= 1'b0;
         EEPROM_SELECT_PIN <= 1'b0;
      end else begin
         EEPROM_SERIAL_OUT_PIN <= (cs && tx[26]) ^ pin_inv[`SEH_PIN_OUT];
         EEPROM_SERIAL_CLOCK_PIN <= sk_high ^ pin_inv[`SEH_PIN_CLK];
         EEPROM_SELECT_PIN <= cs ^ pin_inv[`SEH_PIN_SEL];
      end
   end

   // two-flop synchroniser on the memory's serial output
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         din_s1 <= EEPROM_SERIAL_IN_PIN;
         din_s2 <= din_s1;
      end
   end
endmodule
`default_nettype wire

// File: bench/seh_eeprom_if_chk_chk.sv
// port assertions for the eeprom host interface
`timescale 1ns/1ps
`default_nettype none
module seh_eeprom_if_chk #(
   parameter int SK_HALF_NS = 500,
   parameter int CS_LOW_NS = 250
) (
   // clock, reset and register bus
   input wire logic CLK,
   input wire logic RESET,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire seh_pkg::seh_resp_t S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire seh_pkg::seh_data_t S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   // serial pins
   input wire logic EEPROM_SERIAL_OUT_PIN,
   input wire logic EEPROM_SERIAL_CLOCK_PIN,
   input wire logic EEPROM_SELECT_PIN
);
   import seh_pkg::*;
   localparam int HI = SK_HALF_NS / 25;
   localparam int LO = CS_LOW_NS / 25;
   int hi_cnt;
   int lo_cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   // cycles spent with the serial clock high and the select low
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
      end else begin
         hi_cnt <= EEPROM_SERIAL_CLOCK_PIN ? hi_cnt + 1 : 0;
         lo_cnt <= EEPROM_SELECT_PIN ? 0 : lo_cnt + 1;
      end
   end
   chk_b_follows: assert property
      (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write answer late");
   chk_b_holds: assert property
      (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   chk_r_follows: assert property
      (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   chk_r_byte: assert property
      (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
      else $error("read data above byte");
   chk_aw_busy: assert property
      (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY [*2])
      else $error("second write taken early");
   chk_do_quiet: assert property
      (!EEPROM_SELECT_PIN |-> !EEPROM_SERIAL_OUT_PIN)
      else $error("data out active while deselected");
   chk_sk_half: assert property
      ($fell(EEPROM_SERIAL_CLOCK_PIN) |-> hi_cnt == HI)
      else $error("serial clock high phase wrong");
   chk_cs_gap: assert property
      ($rose(EEPROM_SELECT_PIN) |-> lo_cnt >= LO)
      else $error("select gap too short");
   cover property (S_AXI_BVALID && S_AXI_BREADY);
   cover property (S_AXI_RVALID && S_AXI_ARREADY == 1'b0);
   cover property ($rose(EEPROM_SELECT_PIN));
endmodule
`default_nettype wire

// File: bench/seh_eeprom_model.sv
// behavioural x16 serial eeprom at the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module seh_eeprom_model #(
   parameter int BUSY_NS = 3000
) (
   // pins seen from the memory
   input wire logic sk,
   input wire logic cs,
   input wire logic di,
   input wire logic big,
   output logic dout
);
   logic [15:0] mem [256];
   logic [15:0] sh = '0;
   logic [1:0] op = '0;
   logic [7:0] adr = '0;
   logic wen = 0;
   logic busy = 0;
   logic rd = 0;
   logic flt = 0;
   int n = 0;
   int hdr;
   // start bit, opcode and address clocks
   assign hdr = big ? 11 : 9;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h5a00 | 16'(i);
   // a released line keeps changing instead of holding its last level
   always #40 flt = ~flt;
   assign dout = !cs ? flt : (rd ? sh[15] : !busy);
   // header capture and data shifting on each rising serial clock
   always @(posedge sk) begin
      if (cs) begin
         n++;
         if (n == 1) adr = '0;
         else if (n <= 3) op = {op[0], di};
         else if (n <= hdr) adr = {adr[6:0], di};
         else begin
            sh = (op == 2'b10) ? ((n > hdr + 1) ? sh << 1 : sh) : {sh[14:0], di};
            rd = (op == 2'b10);
         end
         if (n == hdr) begin
            sh = mem[adr];
            wen = wen | (op == 2'b00 && (big ? adr[7:6] : adr[5:4]) == 2'b11);
         end
      end
   end
   always @(posedge cs) begin
      n = 0;
      rd = 0;
   end
   // a complete write frame programs the word, then the memory stays busy
   always @(negedge cs) begin
      if (op == 2'b01 && wen && n >= hdr + 16) begin
         mem[adr] = sh;
         busy = 1;
         #BUSY_NS busy = 0;
      end
   end
endmodule
`default_nettype wire

// File: bench/test_serial_eeprom_host_interface.sv
// self-checking bench for the serial eeprom host interface
`timescale 1ns/1ps
`default_nettype none
`include "seh_consts.svh"
module test_serial_eeprom_host_interface;
   import seh_pkg::*;
   localparam logic [11:0] AM = 12'h3c4, AP = 12'h3c8, AWD = 12'h3cc, AWS = 12'h3d0;
   localparam logic [11:0] ARD = 12'h3d4, ARS = 12'h3d8, APC = 12'h3dc;
   logic clk = 0;
   logic reset = 1;
   logic [11:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, big = 0;
   seh_data_t wdata = 0;
   logic awready, wready, bvalid, arready, rvalid, sdo, sdi, sck, sel;
   seh_resp_t bresp, rresp, r;
   seh_data_t rdata, d;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   seh_eeprom_if #(.SK_HALF_NS(100), .CS_LOW_NS(100)) i_dut (.CLK(clk), .RESET(reset),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EEPROM_SERIAL_IN_PIN(sdi), .EEPROM_SERIAL_OUT_PIN(sdo),
      .EEPROM_SERIAL_CLOCK_PIN(sck), .EEPROM_SELECT_PIN(sel));
   seh_eeprom_model i_mem (.sk(sck), .cs(sel), .di(sdo), .big(big), .dout(sdi));
   always #12.5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic poll(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
      do rd(a); while ((d[7:0] & m) !== v);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset <= 0;
      // outside configuration mode: writes ignored, reads zero, unmapped refused
      wr(AP, 8'h22);
      chk({30'h0, r}, {30'h0, `SEH_RESP_OKAY});
      rd(AWS);
      chk(d, 0);
      rd(12'h100);
      chk({30'h0, r}, {30'h0, `SEH_RESP_SLVERR});
      wr(APC, 8'h01);
      rd(AP);
      chk(d, 0);
      rd(AWS);
      chk(d, 32'h03);
      // large class, write mode, one word at 0x40
      big <= 1;
      wr(AM, 8'h10);
      wr(AWS, 8'h80);
      wr(AP, 8'h40);
      poll(AWS, 8'h03, 8'h03);
      wr(AWD, 8'h34);
      rd(AWS);
      chk(d, 32'h82);
      wr(AWD, 8'h12);
      rd(AWS);
      chk(d, 32'h80);
      poll(AWS, 8'h03, 8'h03);
      rd(AP);
      chk(d, 32'h41);
      // read mode: early read harmless, then low and high byte, then next word
      wr(AWS, 8'h00);
      wr(AP, 8'h40);
      rd(ARD);
      poll(ARS, 8'h01, 8'h01);
      rd(ARD);
      chk(d, 32'h34);
      rd(ARD);
      chk(d, 32'h12);
      rd(ARS);
      chk(d, 0);
      rd(AP);
      chk(d, 32'h41);
      poll(ARS, 8'h01, 8'h01);
      rd(ARD);
      chk(d, 32'h41);
      // lowest block locked; clearing ignored; reads there give zero
      wr(AM, 8'h11);
      wr(AM, 8'h10);
      rd(AM);
      chk(d, 32'h11);
      wr(AP, 8'h05);
      poll(ARS, 8'h01, 8'h01);
      rd(ARD);
      chk(d, 0);
      // small class with six address bits
      big <= 0;
      wr(AM, 8'h00);
      wr(AP, 8'h30);
      poll(ARS, 8'h01, 8'h01);
      rd(ARD);
      chk(d, 32'h30);
      rd(ARD);
      chk(d, 32'h5a);
      close_out();
   end
endmodule
bind seh_eeprom_if seh_eeprom_if_chk #(.SK_HALF_NS(SK_HALF_NS), .CS_LOW_NS(CS_LOW_NS)) i_chk (
   .CLK(CLK), .RESET(RESET), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .EEPROM_SERIAL_OUT_PIN(EEPROM_SERIAL_OUT_PIN),
   .EEPROM_SERIAL_CLOCK_PIN(EEPROM_SERIAL_CLOCK_PIN), .EEPROM_SELECT_PIN(EEPROM_SELECT_PIN));
`default_nettype wire
